/* pkg/sbrd_pkg.sv */
// Types of the sideband request decoder
package sbrd_pkg;
   typedef enum logic [1:0] {
      SBRD_RATE_1X = 2'h0,
      SBRD_RATE_2X = 2'h1,
      SBRD_RATE_4X = 2'h2
   } sbrd_rate_t;
   typedef struct packed {
      logic [47:0] addr;
      logic [3:0] cmd;
      logic [2:0] len;
   } sbrd_req_t;
   typedef struct packed {
      logic [3:0] cmd;
      logic [8:0] mid;
      logic [11:0] up;
      logic [11:0] ext;
   } sbrd_sticky_t;
   typedef enum logic [1:0] {
      SBRD_HI = 2'b01,
      SBRD_LO = 2'b10
   } sbrd_phase_t;
endpackage : sbrd_pkg

/* pkg/sbrd_regs.svh */
// Constants and register map of the sideband request decoder
`ifndef SBRD_REGS_SVH
`define SBRD_REGS_SVH
`define SBRD_CTRL_OFS 8'h00
`define SBRD_STAT_OFS 8'h04
`define SBRD_REQA_OFS 8'h08
`define SBRD_REQB_OFS 8'h0C
`define SBRD_CTRL_RST 32'h0000_0000
`define SBRD_CTRL_EXT_BIT 5
`define SBRD_CTRL_SBEN_BIT 9
`define SBRD_CTRL_RATE_LSB 0
`define SBRD_IDLE_BYTE 8'hFF
`endif

/* rtl/sbrd_decoder.sv */
// Sideband request port decoder with AXI4-Lite control registers
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sbrd_regs.svh"
module sbrd_decoder
   import sbrd_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Sideband link
   input wire logic [7:0] sidebandRequestPort,
   input wire logic interfaceClk,
   input wire logic sidebandSourceStrobe,
   // Request output
   output logic reqValid,
   output sbrd_req_t reqOut,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ----------------------------------------
   // Synchronisers
   // ----------------------------------------
   logic [7:0] portS1_q, portS2_q;
   logic [1:0] clkS_q, stbS_q;
   logic clkP_q, stbP_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         portS1_q <= 8'hFF;
         portS2_q <= 8'hFF;
         clkS_q <= 2'h0;
         stbS_q <= 2'h3;
         clkP_q <= 1'b0;
         stbP_q <= 1'b1;
      end else begin
         portS1_q <= sidebandRequestPort;
         portS2_q <= portS1_q;
         clkS_q <= {clkS_q[0], interfaceClk};
         stbS_q <= {stbS_q[0], sidebandSourceStrobe};
         clkP_q <= clkS_q[1];
         stbP_q <= stbS_q[1];
      end
   end
   logic clkRise, stbFall, stbRise;
   assign clkRise = clkS_q[1] & ~clkP_q;
   assign stbFall = ~stbS_q[1] & stbP_q;
   assign stbRise = stbS_q[1] & ~stbP_q;

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   logic [31:0] ctrl_q, ctrl_d;
   logic extEn, sbEn;
   sbrd_rate_t rate;
   assign extEn = ctrl_q[`SBRD_CTRL_EXT_BIT];
   assign sbEn = ctrl_q[`SBRD_CTRL_SBEN_BIT];
   assign rate = sbrd_rate_t'(ctrl_q[`SBRD_CTRL_RATE_LSB +: 2]);

   // ----------------------------------------
   // Tick capture
   // ----------------------------------------
   // 1x and 4x take a byte per interface clock rise; 2x per strobe edge
   logic tick, tickIsHi;
   always_comb begin
      tick = 1'b0;
      tickIsHi = 1'b0;
      unique case (rate)
         SBRD_RATE_2X: begin
            tick = stbFall | stbRise;
            tickIsHi = stbFall;
         end
         default: begin
            tick = clkRise;
         end
      endcase
   end

   function automatic logic isReserved(input logic [7:0] b);
      isReserved = (b[7:4] == 4'hF) && (b[3:0] != 4'hF);
   endfunction : isReserved

   // ----------------------------------------
   // Decoder state
   // ----------------------------------------
   sbrd_phase_t phase_q, phase_d;
   logic [7:0] hiByte_q, hiByte_d;
   sbrd_sticky_t sticky_q, sticky_d;
   logic fire_q, fire_d;
   sbrd_req_t build;
   logic [15:0] op;
   logic opDone;
   assign op = {hiByte_q, portS2_q};
   always_comb begin
      phase_d = phase_q;
      hiByte_d = hiByte_q;
      sticky_d = sticky_q;
      fire_d = 1'b0;
      opDone = 1'b0;
      build = '0;
      if (!sbEn) begin
         phase_d = SBRD_HI;
      end else if (tick) begin
         unique case (phase_q)
            SBRD_HI: begin
               // An all-ones high byte can only open an idle, so skipping it at every rate
               // realigns a stream that slipped by one byte
               if (portS2_q == `SBRD_IDLE_BYTE) begin
                  phase_d = SBRD_HI;
               end else if (rate == SBRD_RATE_2X && !tickIsHi) begin
                  phase_d = SBRD_HI;
               end else begin
                  hiByte_d = portS2_q;
                  phase_d = SBRD_LO;
               end
            end
            SBRD_LO: begin
               phase_d = SBRD_HI;
               opDone = 1'b1;
            end
            default: begin
               phase_d = SBRD_HI;
            end
         endcase
      end
      if (opDone) begin
         if (!op[15]) begin
            // Rebuild the full request from this op's address and length bits and the sticky fields
            build.len = op[2:0];
            build.addr[14:3] = op[14:3];
            build.addr[2:0] = 3'h0;
            build.addr[23:15] = sticky_q.mid;
            build.addr[31:24] = sticky_q.up[7:0];
            build.addr[35:32] = extEn ? sticky_q.up[11:8] : 4'h0;
            build.addr[47:36] = extEn ? sticky_q.ext : 12'h000;
            build.cmd = sticky_q.cmd;
            fire_d = 1'b1;
         end else if (op[15:14] == 2'b10) begin
            sticky_d.cmd = op[13:10];
            sticky_d.mid = {op[7:0], op[8]};
         end else if (op[15:13] == 3'b110) begin
            sticky_d.up = op[11:0];
         end else if (op[15:12] == 4'hE) begin
            if (extEn) begin
               sticky_d.ext = {op[7:0], op[11:8]};
            end
         end else if (isReserved(op[15:8])) begin
            sticky_d = sticky_q;
         end else begin
            sticky_d = sticky_q;
         end
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= SBRD_HI;
         hiByte_q <= 8'hFF;
         sticky_q <= '0;
         fire_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         hiByte_q <= hiByte_d;
         sticky_q <= sticky_d;
         fire_q <= fire_d;
      end
   end

   sbrd_req_hold uHold (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .wrEn(fire_d),
      .wrData(build),
      .rdData(reqOut)
   );
   assign reqValid = fire_q;

   logic [31:0] reqCount_q, reqCount_d;
   always_comb begin
      reqCount_d = reqCount_q + {31'h0, fire_q};
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reqCount_q <= 32'h0000_0000;
      end else begin
         reqCount_q <= reqCount_d;
      end
   end

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bv_q, bv_d, rv_q, rv_d;
   logic [7:0] awA_q, awA_d;
   logic [31:0] wD_q, wD_d, rD_q, rD_d;
   logic [3:0] wS_q, wS_d;
   logic [1:0] bR_q, bR_d, rR_q, rR_d;
   logic doWr;
   assign s_axi_awready = !awHeld_q && !bv_q;
   assign s_axi_wready = !wHeld_q && !bv_q;
   assign s_axi_arready = !rv_q;
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = bR_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rD_q;
   assign s_axi_rresp = rR_q;
   always_comb begin
      awHeld_d = awHeld_q;
      wHeld_d = wHeld_q;
      awA_d = awA_q;
      wD_d = wD_q;
      wS_d = wS_q;
      bv_d = bv_q;
      bR_d = bR_q;
      rv_d = rv_q;
      rD_d = rD_q;
      rR_d = rR_q;
      ctrl_d = ctrl_q;
      doWr = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         awHeld_d = 1'b1;
         awA_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wHeld_d = 1'b1;
         wD_d = s_axi_wdata;
         wS_d = s_axi_wstrb;
      end
      if (awHeld_q && wHeld_q) begin
         doWr = 1'b1;
         awHeld_d = 1'b0;
         wHeld_d = 1'b0;
         bv_d = 1'b1;
         bR_d = 2'b10;
         if (awA_q == `SBRD_CTRL_OFS) begin
            bR_d = 2'b00;
            for (int i = 0; i < 4; i++) begin
               if (wS_q[i]) begin
                  ctrl_d[i*8 +: 8] = wD_q[i*8 +: 8];
               end
            end
         end else if (awA_q == `SBRD_STAT_OFS || awA_q == `SBRD_REQA_OFS || awA_q == `SBRD_REQB_OFS) begin
            bR_d = 2'b00;
         end
      end
      if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rv_d = 1'b1;
         rR_d = 2'b00;
         unique case (s_axi_araddr)
            `SBRD_CTRL_OFS: rD_d = ctrl_q;
            `SBRD_STAT_OFS: rD_d = reqCount_q;
            `SBRD_REQA_OFS: rD_d = reqOut.addr[31:0];
            `SBRD_REQB_OFS: rD_d = {9'h000, reqOut.len, reqOut.cmd, reqOut.addr[47:32]};
            default: begin
               rD_d = 32'h0000_0000;
               rR_d = 2'b10;
            end
         endcase
      end else if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awA_q <= 8'h00;
         wD_q <= 32'h0000_0000;
         wS_q <= 4'h0;
         bv_q <= 1'b0;
         bR_q <= 2'b00;
         rv_q <= 1'b0;
         rD_q <= 32'h0000_0000;
         rR_q <= 2'b00;
         ctrl_q <= `SBRD_CTRL_RST;
      end else begin
         awHeld_q <= awHeld_d;
         wHeld_q <= wHeld_d;
         awA_q <= awA_d;
         wD_q <= wD_d;
         wS_q <= wS_d;
         bv_q <= bv_d;
         bR_q <= bR_d;
         rv_q <= rv_d;
         rD_q <= rD_d;
         rR_q <= rR_d;
         ctrl_q <= ctrl_d;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence opType1;
      opDone && !op[15];
   endsequence
   type1Fires_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      opType1 |=> reqValid) else $error("Type 1 did not fire");
   onlyType1_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      reqValid |-> $past(opDone) && !$past(op[15])) else $error("Access without Type 1");
   lowZero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      reqValid |-> reqOut.addr[2:0] == 3'h0) else $error("Low address not zero");
   lenTaken_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      opType1 |=> reqOut.len == $past(op[2:0])) else $error("Length mismatch");
   midStored_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (opDone && op[15:14] == 2'b10) |=> sticky_q.mid == {$past(op[7:0]), $past(op[8])} && !reqValid)
      else $error("Type 2 not stored");
   upStored_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (opDone && op[15:13] == 3'b110) |=> sticky_q.up == $past(op[11:0])) else $error("Type 3 not stored");
   extZero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reqValid && !$past(extEn)) |-> reqOut.addr[47:32] == 16'h0000) else $error("Upper address leak");
   idleKeeps_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (sbEn && tick && phase_q == SBRD_HI && portS2_q == 8'hFF) |=> phase_q == SBRD_HI && $stable(sticky_q))
      else $error("Idle changed decoder state");
   offIgnores_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !sbEn |=> !reqValid) else $error("Decode while disabled");
endmodule : sbrd_decoder
`default_nettype wire

/* rtl/sbrd_req_hold.sv */
// Output holding register for the last rebuilt request
`timescale 1ns/1ps
`default_nettype none
module sbrd_req_hold
   import sbrd_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Write side
   input wire logic wrEn,
   input wire sbrd_req_t wrData,
   // Read side
   output sbrd_req_t rdData
);
   sbrd_req_t hold_q;
   sbrd_req_t hold_d;
   always_comb begin
      hold_d = hold_q;
      if (wrEn) begin
         hold_d = wrData;
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_q <= '0;
      end else begin
         hold_q <= hold_d;
      end
   end
   assign rdData = hold_q;
endmodule : sbrd_req_hold
`default_nettype wire

/* tb/sbrd_decoder_test.sv */
// Self-checking bench for the sideband request decoder
`timescale 1ns/1ps
`default_nettype none
`include "sbrd_regs.svh"
module sbrd_decoder_test
   import sbrd_pkg::*;
;
   typedef struct {logic [31:0] ctrl; logic [15:0] op; logic pulse; sbrd_req_t exp;} sbrd_row_t;
   logic sys_clk = 1'b0;
   logic rst_n;
   logic [1:0] rate;
   logic [7:0] sidebandRequestPort;
   logic interfaceClk;
   logic sidebandSourceStrobe;
   logic reqValid;
   sbrd_req_t reqOut;
   sbrd_req_t lastReq;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int num_errors = 0;
   int num_checks = 0;
   int pulses = 0;
   int mark;
   sbrd_row_t rows [11];
   always #2.5 sys_clk = ~sys_clk;
   sbrd_decoder DUT (.sys_clk, .rst_n, .sidebandRequestPort, .interfaceClk, .sidebandSourceStrobe,
      .reqValid, .reqOut, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   sbrd_master_model u_master (.rate, .sidebandRequestPort, .interfaceClk, .sidebandSourceStrobe);
   always @(posedge sys_clk) begin
      if (reqValid === 1'b1) begin
         pulses <= pulses + 1;
         lastReq <= reqOut;
      end
   end
   //------------------------------------------------------------
   // Encoders and bus tasks
   //------------------------------------------------------------
   function automatic logic [15:0] t1(input logic [11:0] a, input logic [2:0] len);
      return {1'b0, a, len};
   endfunction : t1
   function automatic logic [15:0] t2(input logic [3:0] c, input logic [8:0] m, input logic r);
      return {2'b10, c, r, m[0], m[8:1]};
   endfunction : t2
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t register got %h expected %h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_req(input logic ex, input sbrd_req_t exp);
      num_checks++;
      if ((pulses - mark) != int'(ex) || (ex && lastReq !== exp)) begin
         num_errors++;
         $display("CHECK FAILED %0t request count %0d last %h", $time, pulses - mark, lastReq);
      end
   endtask : chk_req
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_write
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_read
   task automatic report_and_stop();
      if (num_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      #200_000;
      num_errors++;
      report_and_stop();
   end
   //------------------------------------------------------------
   // Main sequence
   //------------------------------------------------------------
   initial begin
      logic [31:0] ctrlNow, d;
      logic [1:0] r;
      rst_n = 1'b0;
      rate = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      ctrlNow = 32'h0000_0000;
      rows[0] = '{32'h0000_0000, t1(12'h9B7, 3'd3), 1'b0, '0};
      rows[1] = '{32'h0000_0200, t2(4'h6, 9'h1A5, 1'b0), 1'b0, '0};
      rows[2] = '{32'h0000_0200, 16'hCA5C, 1'b0, '0};
      rows[3] = '{32'h0000_0200, t1(12'h9B7, 3'd3), 1'b1, '{48'h0000_5CD2_CDB8, 4'h6, 3'd3}};
      rows[4] = '{32'h0000_0200, 16'hF700, 1'b0, '0};
      rows[5] = '{32'h0000_0200, t2(4'h7, 9'h0F0, 1'b1), 1'b0, '0};
      rows[6] = '{32'h0000_0200, t1(12'h001, 3'd0), 1'b1, '{48'h0000_5C78_0008, 4'h7, 3'd0}};
      rows[7] = '{32'h0000_0220, 16'hECAB, 1'b0, '0};
      rows[8] = '{32'h0000_0220, 16'hC3C4, 1'b0, '0};
      rows[9] = '{32'h0000_0220, t1(12'hFFF, 3'd7), 1'b1, '{48'hABC3_C478_7FF8, 4'h7, 3'd7}};
      rows[10] = '{32'h0000_0200, t1(12'h002, 3'd1), 1'b1, '{48'h0000_C478_0010, 4'h7, 3'd1}};
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      axi_read(`SBRD_CTRL_OFS, d, r);
      chk_reg({d[31:2], r}, 32'h0000_0000);
      for (int i = 0; i < 11; i++) begin
         if (rows[i].ctrl !== ctrlNow) begin
            axi_write(`SBRD_CTRL_OFS, rows[i].ctrl, r);
            ctrlNow = rows[i].ctrl;
         end
         mark = pulses;
         u_master.send(rows[i].op);
         u_master.idle(3);
         chk_req(rows[i].pulse, rows[i].exp);
      end
      mark = pulses;
      u_master.send(t1(12'h003, 3'd2));
      u_master.send(t1(12'h004, 3'd4));
      u_master.idle(3);
      chk_reg(pulses - mark, 32'h0000_0002);
      mark = pulses - 1;
      chk_req(1'b1, '{48'h0000_C478_0020, 4'h7, 3'd4});
      axi_read(`SBRD_REQA_OFS, d, r);
      chk_reg(d, 32'hC478_0020);
      axi_read(`SBRD_REQB_OFS, d, r);
      chk_reg(d, 32'h0047_0000);
      axi_read(`SBRD_STAT_OFS, d, r);
      chk_reg(d, 32'h0000_0006);
      axi_read(8'h10, d, r);
      chk_reg({d[31:2], r}, 32'h0000_0002);
      axi_write(8'h14, 32'h0000_FFFF, r);
      chk_reg({30'h0, r}, 32'h0000_0002);
      for (int k = 1; k < 3; k++) begin
         axi_write(`SBRD_CTRL_OFS, 32'h0000_0200 | k, r);
         chk_reg({30'h0, r}, 32'h0000_0000);
         rate = k[1:0];
         u_master.idle(2);
         mark = pulses;
         u_master.send(t1(12'h005, 3'd5));
         u_master.idle(3);
         chk_req(1'b1, '{48'h0000_C478_0028, 4'h7, 3'd5});
      end
      // Reset in mid-run clears the request counter and the held request
      rst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      axi_read(`SBRD_STAT_OFS, d, r);
      chk_reg(d, 32'h0000_0000);
      axi_read(`SBRD_REQA_OFS, d, r);
      chk_reg(d, 32'h0000_0000);
      report_and_stop();
   end
endmodule : sbrd_decoder_test
`default_nettype wire

/* tb/sbrd_master_model.sv */
// Behavioural graphics master that drives the sideband request port
`timescale 1ns/1ps
`default_nettype none
module sbrd_master_model
   import sbrd_pkg::*;
(
   // Transfer rate
   input wire logic [1:0] rate,
   // Sideband link
   output logic [7:0] sidebandRequestPort,
   output logic interfaceClk,
   output logic sidebandSourceStrobe
);
   initial begin
      interfaceClk = 1'b0;
      sidebandRequestPort = 8'hFF;
      sidebandSourceStrobe = 1'b1;
   end
   always #24 interfaceClk = ~interfaceClk;
   // Byte changes on the falling edge so it is stable at the rising edge
   task automatic tick(input logic [7:0] b);
      @(negedge interfaceClk) sidebandRequestPort <= b;
   endtask : tick
   // Opcode byte first; callers keep reserved bits zero unless a test breaks them
   task automatic send(input logic [15:0] op);
      if (rate == 2'h1) begin
         tick(op[15:8]);
         #12 sidebandSourceStrobe <= 1'b0;
         #12 sidebandRequestPort <= op[7:0];
         #12 sidebandSourceStrobe <= 1'b1;
      end else begin
         tick(op[15:8]);
         tick(op[7:0]);
      end
   endtask : send
   // Idle is one byte at 1x and a full pair otherwise
   task automatic idle(input int n);
      repeat (n) begin
         if (rate == 2'h0) begin
            tick(8'hFF);
         end else begin
            send(16'hFFFF);
         end
      end
   endtask : idle
endmodule : sbrd_master_model
`default_nettype wire
